// [hpsb_bridge.sv]
// Behaviour
// R1: A processor read of PCI space blocks its issuer until the read completes.
// R2: While one read is in progress, a second processor read is held off.
// R3: Processor writes are posted without stalling; many may be outstanding. The bridge holds writes off while a processor read is in progress.
// R4: Posted writes reach PCI in the order they were issued.
// R5: Writes from different processors need no relative order.
// R6: Every posted write is flushed to PCI before a processor read completes.
// R7: DMA read and write order is kept when both hit the same cache line.
// R8: A DMA read may pass an earlier DMA write to a different line.
// R9: The DMA ordering cache line is a whole multiple of 32 bytes.
// R10: DMA reads may overtake processor writes still posted in the bridge.
// R11: Host side is big-endian, PCI side little-endian; bridge converts.
// R12: Multibyte words are byte-reversed in hardware between the buses.
// R13: Swapping acts per 32-bit word so byte arrays keep their order.
// R14: Single-byte transfers pass through without reordering.
// R15: Host follows a critical posted write with a read of that card.
// R16: Host reads back a cleared interrupt request register before leaving service.
// R17: Strictly ordered flags fit in 32 bytes aligned to a cache line.
// R18: A full posted queue stalls processor writes, never drops or reorders them.
`timescale 1ns/100ps
module hpsb_bridge #(
  parameter int DEPTH = hpsb_pkg::POST_DEPTH,
  parameter int LINE_BYTES = hpsb_pkg::CACHE_LINE_BYTES
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RESET_I,
  // Processor side
  input wire logic HOST_VALID_I,
  input wire hpsb_pkg::hpsb_host_req_s HOST_REQ_I,
  output logic HOST_READY_O,
  output logic HOST_RVALID_O,
  output logic [hpsb_pkg::DATA_W-1:0] HOST_RDATA_O,
  output logic [hpsb_pkg::PROC_W-1:0] HOST_RPROC_O,
  // PCI master side
  output logic PCI_VALID_O,
  output hpsb_pkg::hpsb_bus_req_s PCI_REQ_O,
  input wire logic PCI_DONE_I,
  input wire logic [hpsb_pkg::DATA_W-1:0] PCI_RDATA_I,
  // DMA from PCI masters
  input wire logic DMA_VALID_I,
  input wire hpsb_pkg::hpsb_bus_req_s DMA_REQ_I,
  output logic DMA_WR_READY_O,
  output logic DMA_RD_READY_O,
  output logic DMA_RVALID_O,
  output logic [hpsb_pkg::DATA_W-1:0] DMA_RDATA_O,
  // Host memory side
  output logic MEM_VALID_O,
  output hpsb_pkg::hpsb_bus_req_s MEM_REQ_O,
  input wire logic MEM_DONE_I,
  input wire logic [hpsb_pkg::DATA_W-1:0] MEM_RDATA_I
);

  localparam int FW = $bits(hpsb_pkg::hpsb_bus_req_s);
  localparam int LW = $clog2(DEPTH+1);
  localparam int LINE_LSB = $clog2(LINE_BYTES);
  localparam logic [LW-1:0] STALL_MARK = LW'(DEPTH - 2);

  // ****************************************************************
  // Processor request path
  // ****************************************************************
  hpsb_pkg::hpsb_rd_e rd_state_r;
  hpsb_pkg::hpsb_bus_req_s rd_req_r;
  hpsb_pkg::hpsb_bus_req_s host_wr;
  hpsb_pkg::hpsb_bus_req_s fifo_head;
  logic [hpsb_pkg::DATA_W-1:0] host_wdata_sw;
  logic [hpsb_pkg::DATA_W-1:0] pci_rdata_sw;
  logic [LW-1:0] fifo_level;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic wr_take;
  logic rd_take;
  logic fifo_pop;
  logic rd_issue;
  logic rd_done;

  assign wr_take = HOST_VALID_I && HOST_READY_O && HOST_REQ_I.write && fifo_in_ready;
  assign rd_take = HOST_VALID_I && HOST_READY_O && !HOST_REQ_I.write;
  assign fifo_pop = !PCI_VALID_O && fifo_out_valid;
  assign rd_issue = !PCI_VALID_O && !fifo_out_valid && rd_state_r == hpsb_pkg::RD_FLUSH;
  assign rd_done = PCI_VALID_O && PCI_DONE_I && !PCI_REQ_O.write;

  always_comb begin
    host_wr.write = 1'b1;
    host_wr.byte_mode = HOST_REQ_I.byte_mode;
    host_wr.addr = HOST_REQ_I.addr;
    host_wr.data = host_wdata_sw;
  end

  // Host word data is reversed before it is queued for the little-endian bus.
  hpsb_swap #(.W(hpsb_pkg::DATA_W)) u_swap_hw (
    .byte_mode_i(HOST_REQ_I.byte_mode),
    .data_i(HOST_REQ_I.data),
    .data_o(host_wdata_sw)
  ); // R11

  hpsb_swap #(.W(hpsb_pkg::DATA_W)) u_swap_hr (
    .byte_mode_i(rd_req_r.byte_mode),
    .data_i(PCI_RDATA_I),
    .data_o(pci_rdata_sw)
  ); // R12

  // A single queue for all processors keeps each issuer's order; order between
  // issuers is simply arrival order, which is stricter than needed.
  hpsb_fifo #(.WIDTH(FW), .DEPTH(DEPTH)) u_post (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .in_valid_i(wr_take),
    .in_ready_o(fifo_in_ready),
    .in_data_i(host_wr),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_head),
    .level_o(fifo_level)
  ); // R4 R5

  // Ready drops two entries early so the registered ready never overfills.
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      HOST_READY_O <= hpsb_pkg::RST_READY;
    end else begin
      HOST_READY_O <= ((rd_state_r == hpsb_pkg::RD_IDLE && !rd_take)
                       || rd_state_r == hpsb_pkg::RD_RESP)
                      && fifo_level < STALL_MARK; // R1 R2 R3 R18
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      rd_state_r <= hpsb_pkg::RD_IDLE;
      rd_req_r <= '0;
      HOST_RPROC_O <= '0;
    end else begin
      case (rd_state_r)
        hpsb_pkg::RD_IDLE: begin
          if (rd_take) begin
            rd_state_r <= hpsb_pkg::RD_FLUSH;
            rd_req_r <= '{write: 1'b0, byte_mode: HOST_REQ_I.byte_mode,
                          addr: HOST_REQ_I.addr, data: '0};
            HOST_RPROC_O <= HOST_REQ_I.proc_id;
          end
        end
        hpsb_pkg::RD_FLUSH: begin
          if (rd_issue) begin
            rd_state_r <= hpsb_pkg::RD_BUS; // R6
          end
        end
        hpsb_pkg::RD_BUS: begin
          if (rd_done) begin
            rd_state_r <= hpsb_pkg::RD_RESP;
          end
        end
        hpsb_pkg::RD_RESP: begin
          rd_state_r <= hpsb_pkg::RD_IDLE;
        end
        default: begin
          rd_state_r <= hpsb_pkg::RD_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      HOST_RVALID_O <= hpsb_pkg::RST_VALID;
      HOST_RDATA_O <= '0;
    end else begin
      HOST_RVALID_O <= rd_done;
      if (rd_done) begin
        HOST_RDATA_O <= pci_rdata_sw; // R12 R13 R14
      end
    end
  end

  // ****************************************************************
  // PCI master engine
  // ****************************************************************
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      PCI_VALID_O <= hpsb_pkg::RST_VALID;
      PCI_REQ_O <= '0;
    end else if (PCI_VALID_O) begin
      if (PCI_DONE_I) begin
        PCI_VALID_O <= 1'b0;
      end
    end else if (fifo_out_valid) begin
      PCI_VALID_O <= 1'b1;
      PCI_REQ_O <= fifo_head; // R4
    end else if (rd_issue) begin
      PCI_VALID_O <= 1'b1;
      PCI_REQ_O <= rd_req_r; // R6
    end
  end

  // ****************************************************************
  // DMA path to host memory
  // ****************************************************************
  // DMA buffers are independent of the posted queue, so DMA reads never wait
  // behind processor writes.
  hpsb_pkg::hpsb_bus_req_s dwr_q_r;
  hpsb_pkg::hpsb_bus_req_s drd_q_r;
  logic [hpsb_pkg::DATA_W-1:0] dma_wdata_sw;
  logic [hpsb_pkg::DATA_W-1:0] mem_rdata_sw;
  logic dwr_v_r;
  logic drd_v_r;
  logic rd_older_r;
  logic dwr_take;
  logic drd_take;
  logic dwr_done;
  logic drd_done;
  logic same_line;
  logic mem_issue_rd;
  logic mem_issue_wr;

  assign dwr_take = DMA_VALID_I && DMA_REQ_I.write && DMA_WR_READY_O;
  assign drd_take = DMA_VALID_I && !DMA_REQ_I.write && DMA_RD_READY_O;
  assign dwr_done = MEM_VALID_O && MEM_DONE_I && MEM_REQ_O.write;
  assign drd_done = MEM_VALID_O && MEM_DONE_I && !MEM_REQ_O.write;
  assign same_line = dwr_q_r.addr[hpsb_pkg::ADDR_W-1:LINE_LSB]
                     == drd_q_r.addr[hpsb_pkg::ADDR_W-1:LINE_LSB]; // R7 R9
  assign mem_issue_rd = !MEM_VALID_O && drd_v_r && (!dwr_v_r || rd_older_r || !same_line); // R8 R10
  assign mem_issue_wr = !MEM_VALID_O && dwr_v_r && !mem_issue_rd; // R7

  hpsb_swap #(.W(hpsb_pkg::DATA_W)) u_swap_dw (
    .byte_mode_i(DMA_REQ_I.byte_mode),
    .data_i(DMA_REQ_I.data),
    .data_o(dma_wdata_sw)
  ); // R13

  hpsb_swap #(.W(hpsb_pkg::DATA_W)) u_swap_dr (
    .byte_mode_i(drd_q_r.byte_mode),
    .data_i(MEM_RDATA_I),
    .data_o(mem_rdata_sw)
  ); // R14

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      dwr_v_r <= 1'b0;
      drd_v_r <= 1'b0;
      dwr_q_r <= '0;
      drd_q_r <= '0;
      rd_older_r <= 1'b0;
      DMA_WR_READY_O <= hpsb_pkg::RST_READY;
      DMA_RD_READY_O <= hpsb_pkg::RST_READY;
    end else begin
      if (dwr_take) begin
        dwr_v_r <= 1'b1;
        dwr_q_r <= '{write: 1'b1, byte_mode: DMA_REQ_I.byte_mode,
                     addr: DMA_REQ_I.addr, data: dma_wdata_sw};
      end else if (dwr_done) begin
        dwr_v_r <= 1'b0;
      end
      if (drd_take) begin
        drd_v_r <= 1'b1;
        drd_q_r <= DMA_REQ_I;
        rd_older_r <= !dwr_v_r || dwr_done; // R7
      end else if (drd_done) begin
        drd_v_r <= 1'b0;
      end else if (dwr_done) begin
        rd_older_r <= 1'b1;
      end
      DMA_WR_READY_O <= !(dwr_take || (dwr_v_r && !dwr_done));
      DMA_RD_READY_O <= !(drd_take || (drd_v_r && !drd_done));
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      MEM_VALID_O <= hpsb_pkg::RST_VALID;
      MEM_REQ_O <= '0;
    end else if (MEM_VALID_O) begin
      if (MEM_DONE_I) begin
        MEM_VALID_O <= 1'b0;
      end
    end else if (mem_issue_rd) begin
      MEM_VALID_O <= 1'b1;
      MEM_REQ_O <= drd_q_r; // R8
    end else if (mem_issue_wr) begin
      MEM_VALID_O <= 1'b1;
      MEM_REQ_O <= dwr_q_r;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      DMA_RVALID_O <= hpsb_pkg::RST_VALID;
      DMA_RDATA_O <= '0;
    end else begin
      DMA_RVALID_O <= drd_done;
      if (drd_done) begin
        DMA_RDATA_O <= mem_rdata_sw; // R12
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_read_blocks;
    @(posedge CLK_I) disable iff (RESET_I)
    rd_take |=> !HOST_READY_O ##1 (rd_state_r != hpsb_pkg::RD_IDLE);
  endproperty
  a_read_blocks: assert property (p_read_blocks) else $error("ready after read take"); // R1

  property p_second_read_held;
    @(posedge CLK_I) disable iff (RESET_I)
    (rd_state_r inside {hpsb_pkg::RD_FLUSH, hpsb_pkg::RD_BUS}) |-> !HOST_READY_O;
  endproperty
  a_second_read_held: assert property (p_second_read_held) else $error("read not held off"); // R2

  property p_write_posted;
    @(posedge CLK_I) disable iff (RESET_I)
    wr_take |=> (fifo_level != '0 || PCI_VALID_O);
  endproperty
  a_write_posted: assert property (p_write_posted) else $error("posted write lost"); // R3

  property p_write_order;
    @(posedge CLK_I) disable iff (RESET_I)
    fifo_pop |=> PCI_VALID_O && PCI_REQ_O == $past(fifo_head);
  endproperty
  a_write_order: assert property (p_write_order) else $error("queue head not issued"); // R4

  property p_flush_first;
    @(posedge CLK_I) disable iff (RESET_I)
    $rose(PCI_VALID_O) && !PCI_REQ_O.write |-> $past(fifo_level) == '0;
  endproperty
  a_flush_first: assert property (p_flush_first) else $error("read before flush"); // R6

  property p_read_done_empty;
    @(posedge CLK_I) disable iff (RESET_I)
    HOST_RVALID_O |-> fifo_level == '0 && rd_state_r == hpsb_pkg::RD_RESP;
  endproperty
  a_read_done_empty: assert property (p_read_done_empty) else $error("writes left at read end"); // R6

  property p_same_line_order;
    @(posedge CLK_I) disable iff (RESET_I)
    mem_issue_rd && dwr_v_r && same_line |-> rd_older_r;
  endproperty
  a_same_line_order: assert property (p_same_line_order) else $error("read passed same line"); // R7

  property p_line_granule;
    @(posedge CLK_I) disable iff (RESET_I)
    1'b1 |-> (LINE_BYTES % hpsb_pkg::LINE_GRANULE_BYTES) == 0;
  endproperty
  a_line_granule: assert property (p_line_granule) else $error("bad line size"); // R9

  property p_word_swap;
    @(posedge CLK_I) disable iff (RESET_I)
    rd_done && !rd_req_r.byte_mode |=>
      HOST_RDATA_O == {$past(PCI_RDATA_I[7:0]), $past(PCI_RDATA_I[15:8]),
                       $past(PCI_RDATA_I[23:16]), $past(PCI_RDATA_I[31:24])}
      && HOST_RVALID_O;
  endproperty
  a_word_swap: assert property (p_word_swap) else $error("word not swapped"); // R12

  property p_byte_pass;
    @(posedge CLK_I) disable iff (RESET_I)
    drd_done && drd_q_r.byte_mode |=> DMA_RDATA_O[7:0] == $past(MEM_RDATA_I[7:0]);
  endproperty
  a_byte_pass: assert property (p_byte_pass) else $error("byte reordered"); // R14

  property p_full_stalls;
    @(posedge CLK_I) disable iff (RESET_I)
    fifo_level >= STALL_MARK |=> !HOST_READY_O;
  endproperty
  a_full_stalls: assert property (p_full_stalls) else $error("write accepted when full"); // R18

  property p_cov_flush;
    @(posedge CLK_I) disable iff (RESET_I)
    rd_take && fifo_level != '0 ##[1:300] HOST_RVALID_O;
  endproperty
  c_cov_flush: cover property (p_cov_flush);

  property p_cov_pass;
    @(posedge CLK_I) disable iff (RESET_I)
    mem_issue_rd && dwr_v_r && !rd_older_r;
  endproperty
  c_cov_pass: cover property (p_cov_pass);

  property p_cov_full;
    @(posedge CLK_I) disable iff (RESET_I)
    fifo_level >= STALL_MARK && HOST_VALID_I;
  endproperty
  c_cov_full: cover property (p_cov_full);

endmodule // hpsb_bridge

// [hpsb_card_model.sv]
`timescale 1ns/100ps
module hpsb_card_model (
  // Clock, reset and pacing
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [7:0] pci_lat_i,
  input wire logic [7:0] mem_lat_i,
  // PCI target
  input wire logic pci_valid_i,
  input wire hpsb_pkg::hpsb_bus_req_s pci_req_i,
  output logic pci_done_o,
  output logic [31:0] pci_rdata_o,
  // Host memory
  input wire logic mem_valid_i,
  input wire hpsb_pkg::hpsb_bus_req_s mem_req_i,
  output logic mem_done_o,
  output logic [31:0] mem_rdata_o
);
  // ****************************************************************
  // Card registers and host memory
  // ****************************************************************
  // Idle data lines toggle every cycle, so a stale word never passes for an answer.
  logic [31:0] regs [16];
  logic [31:0] mem [64];
  logic [63:0] pci_log [$];
  logic [32:0] mem_log [$];
  int pci_cnt;
  int mem_cnt;

  always @(posedge clk_i) begin
    if (reset_i) begin
      pci_done_o <= 1'b0;
      pci_rdata_o <= 32'h5A5A_5A5A;
      pci_cnt = 0;
    end else if (!pci_done_o && pci_valid_i && pci_cnt >= int'(pci_lat_i)) begin
      pci_cnt = 0;
      pci_done_o <= 1'b1;
      pci_rdata_o <= regs[pci_req_i.addr[5:2]];
      if (pci_req_i.write) begin
        regs[pci_req_i.addr[5:2]] = pci_req_i.data;
        pci_log.push_back({pci_req_i.addr, pci_req_i.data});
      end
    end else begin
      pci_done_o <= 1'b0;
      pci_rdata_o <= ~pci_rdata_o;
      if (pci_valid_i && !pci_done_o) pci_cnt++;
    end
  end

  always @(posedge clk_i) begin
    if (reset_i) begin
      mem_done_o <= 1'b0;
      mem_rdata_o <= 32'hA5A5_A5A5;
      mem_cnt = 0;
      for (int i = 0; i < 64; i++) mem[i] = {24'h01_0203, 8'(i)};
    end else if (!mem_done_o && mem_valid_i && mem_cnt >= int'(mem_lat_i)) begin
      mem_cnt = 0;
      mem_done_o <= 1'b1;
      mem_rdata_o <= mem[mem_req_i.addr[7:2]];
      mem_log.push_back({mem_req_i.write, mem_req_i.addr});
      if (mem_req_i.write) mem[mem_req_i.addr[7:2]] = mem_req_i.data;
    end else begin
      mem_done_o <= 1'b0;
      mem_rdata_o <= ~mem_rdata_o;
      if (mem_valid_i && !mem_done_o) mem_cnt++;
    end
  end
endmodule // hpsb_card_model

// [hpsb_fifo.sv]
`timescale 1ns/100ps
module hpsb_fifo #(
  parameter int WIDTH = 66,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  // Fill level
  output logic [$clog2(DEPTH+1)-1:0] level_o
);

  localparam int PW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [LW-1:0] level_r;
  logic push;
  logic pop;

  assign in_ready_o = level_r != LW'(DEPTH);
  assign out_valid_o = level_r != '0;
  assign out_data_o = mem_r[rd_ptr_r];
  assign level_o = level_r;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // ****************************************************************
  // Storage and pointers
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      level_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= PW'(wr_ptr_r + 1'b1);
      end
      if (pop) begin
        rd_ptr_r <= PW'(rd_ptr_r + 1'b1);
      end
      if (push && !pop) begin
        level_r <= LW'(level_r + 1'b1);
      end else if (pop && !push) begin
        level_r <= LW'(level_r - 1'b1);
      end
    end
  end

endmodule // hpsb_fifo

// [hpsb_pkg.sv]
package hpsb_pkg;

  // ****************************************************************
  // Widths, depths and granules
  // ****************************************************************
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int PROC_W = 2;
  localparam int POST_DEPTH = 16;
  localparam int CACHE_LINE_BYTES = 32;
  localparam int LINE_GRANULE_BYTES = 32;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic RST_READY = 1'b0;
  localparam logic RST_VALID = 1'b0;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [3:0] {
    RD_IDLE = 4'h1,
    RD_FLUSH = 4'h2,
    RD_BUS = 4'h4,
    RD_RESP = 4'h8
  } hpsb_rd_e;

  typedef struct packed {
    logic write;
    logic byte_mode;
    logic [PROC_W-1:0] proc_id;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } hpsb_host_req_s;

  typedef struct packed {
    logic write;
    logic byte_mode;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } hpsb_bus_req_s;

endpackage

// [hpsb_swap.sv]
`timescale 1ns/100ps
module hpsb_swap #(
  parameter int W = 32
) (
  // Control
  input wire logic byte_mode_i,
  // Data
  input wire logic [W-1:0] data_i,
  output logic [W-1:0] data_o
);

  localparam int NB = W / 8;

  // ****************************************************************
  // Lane reversal
  // ****************************************************************
  // Single bytes ride lane zero untouched; whole words are reversed.
  for (genvar i = 0; i < NB; i++) begin : g_lane
    assign data_o[8*i +: 8] = byte_mode_i ? data_i[8*i +: 8] : data_i[8*(NB-1-i) +: 8];
  end

endmodule // hpsb_swap

// [hpsb_tb.sv]
`timescale 1ns/100ps
module tb;
  localparam logic [31:0] IRQ_REQ_ADDR = 32'h0000_003C;
  logic clk, rst, host_valid, host_ready, host_rvalid;
  hpsb_pkg::hpsb_host_req_s host_req;
  logic [31:0] host_rdata, pci_rdata, dma_rdata, mem_rdata;
  logic [1:0] host_rproc;
  logic pci_valid, pci_done, dma_valid, dma_wr_ready, dma_rd_ready, dma_rvalid;
  logic mem_valid, mem_done;
  hpsb_pkg::hpsb_bus_req_s pci_req, dma_req, mem_req;
  logic [7:0] pci_lat, mem_lat;
  int n_errors = 0;
  int checks_done = 0;

  hpsb_bridge i_dut (.CLK_I(clk), .RESET_I(rst), .HOST_VALID_I(host_valid),
    .HOST_REQ_I(host_req), .HOST_READY_O(host_ready), .HOST_RVALID_O(host_rvalid),
    .HOST_RDATA_O(host_rdata), .HOST_RPROC_O(host_rproc), .PCI_VALID_O(pci_valid),
    .PCI_REQ_O(pci_req), .PCI_DONE_I(pci_done), .PCI_RDATA_I(pci_rdata),
    .DMA_VALID_I(dma_valid), .DMA_REQ_I(dma_req), .DMA_WR_READY_O(dma_wr_ready),
    .DMA_RD_READY_O(dma_rd_ready), .DMA_RVALID_O(dma_rvalid), .DMA_RDATA_O(dma_rdata),
    .MEM_VALID_O(mem_valid), .MEM_REQ_O(mem_req), .MEM_DONE_I(mem_done),
    .MEM_RDATA_I(mem_rdata));

  hpsb_card_model i_card (.clk_i(clk), .reset_i(rst), .pci_lat_i(pci_lat),
    .mem_lat_i(mem_lat), .pci_valid_i(pci_valid), .pci_req_i(pci_req),
    .pci_done_o(pci_done), .pci_rdata_o(pci_rdata), .mem_valid_i(mem_valid),
    .mem_req_i(mem_req), .mem_done_o(mem_done), .mem_rdata_o(mem_rdata));

  // ****************************************************************
  // Checking and bus tasks
  // ****************************************************************
  function automatic logic [31:0] sw(input logic [31:0] d);
    return {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      n_errors++;
      $display("wrong value wait cycles expected %0d seen %0d", lim - 1, n);
      wrap_up();
    end
  endtask

  // Called at a falling edge; returns one falling edge after the take, valid still high.
  task automatic host_op(input logic w, input logic bm, input logic [1:0] p,
                         input logic [31:0] a, input logic [31:0] d, output int waits);
    host_valid = 1'b1;
    host_req = '{write: w, byte_mode: bm, proc_id: p, addr: a, data: d};
    for (waits = 0; waits < 400 && host_ready !== 1'b1; waits++) @(negedge clk);
    bound(waits, 400);
    @(negedge clk);
  endtask

  task automatic get_reply(input logic [1:0] p, output logic [31:0] q);
    int n;
    for (n = 0; n < 400 && host_rvalid !== 1'b1; n++) @(negedge clk);
    bound(n, 400);
    chk("reply owner", p, host_rproc);
    q = host_rdata;
    @(negedge clk);
  endtask

  task automatic host_rd(input logic bm, input logic [1:0] p, input logic [31:0] a,
                         output logic [31:0] q);
    int w;
    host_op(1'b0, bm, p, a, 32'h0, w);
    host_valid = 1'b0;
    get_reply(p, q);
  endtask

  task automatic dma_op(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    dma_valid = 1'b1;
    dma_req = '{write: w, byte_mode: 1'b0, addr: a, data: d};
    for (n = 0; n < 400 && (w ? dma_wr_ready : dma_rd_ready) !== 1'b1; n++) @(negedge clk);
    bound(n, 400);
    @(negedge clk);
  endtask

  task automatic dma_rd(input logic [31:0] a, output logic [31:0] q);
    int n;
    dma_op(1'b0, a, 32'h0);
    dma_valid = 1'b0;
    for (n = 0; n < 400 && dma_rvalid !== 1'b1; n++) @(negedge clk);
    bound(n, 400);
    q = dma_rdata;
    @(negedge clk);
  endtask

  task automatic wait_pci(input int cnt, input int lim);
    int n;
    for (n = 0; n < lim && i_card.pci_log.size() < cnt; n++) @(negedge clk);
    bound(n, lim);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_post_order();
    int w;
    pci_lat = 8'd20;
    for (int i = 0; i < 4; i++) begin
      host_op(1'b1, 1'b0, 2'(i), 32'(4 * i), {8'(i), 24'hA1B2C3}, w);
      chk("write stall", 0, w);
    end
    host_valid = 1'b0;
    wait_pci(4, 400);
    for (int i = 0; i < 4; i++) begin
      chk("pci write", {32'(4 * i), sw({8'(i), 24'hA1B2C3})}, i_card.pci_log[i]);
    end
  endtask

  task automatic t_read_flush();
    int n;
    int w;
    logic [31:0] q;
    pci_lat = 8'd10;
    i_card.pci_log.delete();
    host_op(1'b1, 1'b0, 2'h0, 32'h0, 32'h1234_5678, w);
    host_op(1'b1, 1'b0, 2'h1, 32'h4, 32'hCAFE_0001, w);
    host_op(1'b1, 1'b0, 2'h0, IRQ_REQ_ADDR, 32'h0000_00F0, w);
    host_op(1'b0, 1'b0, 2'h0, IRQ_REQ_ADDR, 32'h0, w);
    host_req.proc_id = 2'h1;
    host_req.addr = 32'h0;
    for (n = 0; n < 400 && host_rvalid !== 1'b1; n++) begin
      chk("ready during read", 1'b0, host_ready);
      @(negedge clk);
    end
    bound(n, 400);
    chk("writes flushed", 3, i_card.pci_log.size());
    chk("read data", 32'h0000_00F0, host_rdata);
    host_op(1'b0, 1'b0, 2'h1, 32'h0, 32'h0, w);
    host_valid = 1'b0;
    get_reply(2'h1, q);
    chk("second read", 32'h1234_5678, q);
  endtask

  task automatic t_byte();
    int w;
    logic [31:0] q;
    host_op(1'b1, 1'b1, 2'h2, 32'h8, 32'h0000_00A5, w);
    host_rd(1'b1, 2'h2, 32'h8, q);
    chk("pci byte lane", 8'hA5, i_card.pci_log[$][7:0]);
    chk("host byte lane", 8'hA5, q[7:0]);
  endtask

  task automatic t_queue_full();
    int w;
    int stall;
    // Slow card so the posted queue fills and refuses.
    pci_lat = 8'd30;
    stall = 0;
    i_card.pci_log.delete();
    for (int i = 0; i < 20; i++) begin
      host_op(1'b1, 1'b0, 2'h3, 32'h10, 32'h0300_0000 + 32'(i), w);
      if (w > 0 && stall == 0) stall = i + 1;
    end
    host_valid = 1'b0;
    chk("stall point", 1'b1, stall >= 14 && stall <= 18);
    wait_pci(20, 1000);
    for (int i = 0; i < 20; i++) begin
      chk("drained write", sw(32'h0300_0000 + 32'(i)), i_card.pci_log[i][31:0]);
    end
  endtask

  task automatic t_dma();
    int w;
    logic [31:0] q;
    pci_lat = 8'd200;
    mem_lat = 8'd6;
    i_card.pci_log.delete();
    i_card.mem_log.delete();
    host_op(1'b1, 1'b0, 2'h0, 32'h14, 32'h5555_AAAA, w);
    host_valid = 1'b0;
    dma_op(1'b1, 32'h104, 32'h1122_3344);
    dma_rd(32'h11C, q);
    chk("line order first", {1'b1, 32'h104}, i_card.mem_log[0]);
    chk("line order second", {1'b0, 32'h11C}, i_card.mem_log[1]);
    chk("memory word", sw(32'h1122_3344), i_card.mem[1]);
    dma_rd(32'h104, q);
    chk("dma read back", 32'h1122_3344, q);
    dma_op(1'b1, 32'h200, 32'h0BAD_F00D);
    dma_rd(32'h120, q);
    chk("other line read", 32'h0803_0201, q);
    chk("pci still posted", 0, i_card.pci_log.size());
    wait_pci(1, 1000);
  endtask

  // ****************************************************************
  // Clock, reset and run
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    rst = 1'b1;
    host_valid = 1'b0;
    host_req = '0;
    dma_valid = 1'b0;
    dma_req = '0;
    pci_lat = 8'h0;
    mem_lat = 8'h0;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    t_post_order();
    t_read_flush();
    t_byte();
    t_queue_full();
    t_dma();
    wrap_up();
  end
endmodule // tb
